// *** inc/err_defines.svh ***
// Timing counts and encodings for the error relay status indicator
`ifndef ERR_DEFINES_SVH
`define ERR_DEFINES_SVH
`define ERR_CLK_HZ        200000000
`define ERR_STEP_S        1
`define ERR_STEP_CYC      (`ERR_CLK_HZ * `ERR_STEP_S)
`define ERR_INIT_CYC      1000
`define ERR_SEL_A_REF1    1'b0
`define ERR_SEL_A_EVT     1'b1
`define ERR_SEL_B_REF2    1'b0
`define ERR_SEL_B_PULSE   1'b1
`define ERR_SEL_C_SWITCH  2'h0
`define ERR_SEL_C_10M     2'h1
`define ERR_SEL_C_EVT     2'h2
`endif

// *** inc/err_pkg.sv ***
// Types for the error relay status indicator
package err_pkg;
    typedef enum logic [2:0] {
        ERR_COL_OFF,
        ERR_COL_RED,
        ERR_COL_YELLOW,
        ERR_COL_GREEN,
        ERR_COL_BLUE
    } err_col_t;
    typedef enum {
        ERR_PH_INIT,
        ERR_PH_BOOT,
        ERR_PH_NORMAL
    } err_phase_t;
endpackage

// *** core/err_sync.sv ***
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module err_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } err_sync_t;
    err_sync_t st_r;
    err_sync_t st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;
endmodule

// *** core/err_relay.sv ***
// Contract
// - Clock synchronous: relay held normally-open
// - Monitored error: relay goes normally-closed
// - Default: A clock one, B two, C switch
// - Jumper selects each relay's alarm source
// - Boot: LEDs A, B, C cycle red yellow green off
// - Normal: LED A green, red on error
// - Normal: LED B green, red on error
// - Normal: LED C follows notification event
`timescale 1ns/1ps
`include "err_defines.svh"
module err_relay
    import err_pkg::*;
#(
    parameter int STEP_CYC = `ERR_STEP_CYC,
    parameter int INIT_CYC = `ERR_INIT_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       ref1_sync,
    input  wire logic       ref2_sync,
    input  wire logic       redundancy_switch_controller_ok,
    input  wire logic       pulse_per_second_ok,
    input  wire logic       ten_mhz_ok,
    input  wire logic       notify_err,
    input  wire logic       sel_a,
    input  wire logic       sel_b,
    input  wire logic [1:0] sel_c,
    output logic            relay_a_nc,
    output logic            relay_b_nc,
    output logic            relay_c_nc,
    output err_col_t        led_st,
    output err_col_t        led_a,
    output err_col_t        led_b,
    output err_col_t        led_c,
    output logic            normal_mode
);
    logic [9:0] raw;
    logic [9:0] syn;

    typedef struct packed {
        err_phase_t  phase;
        logic [31:0] cnt;
        logic [1:0]  step;
        logic        ra;
        logic        rb;
        logic        rc;
        err_col_t    st;
        err_col_t    a;
        err_col_t    b;
        err_col_t    c;
    } err_state_t;
    err_state_t st_r;
    err_state_t st_nxt;

    // Pins and jumpers come from outside the clock domain
    assign raw = {sel_c, sel_b, sel_a, notify_err, ten_mhz_ok,
                  pulse_per_second_ok, redundancy_switch_controller_ok,
                  ref2_sync, ref1_sync};

    err_sync #(
        .W (10)
    ) u_sync (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .d       (raw),
        .q       (syn)
    );

    function automatic err_col_t health(input logic err);
        health = err ? ERR_COL_RED : ERR_COL_GREEN;
    endfunction

    function automatic err_col_t boot_col(input logic [1:0] s);
        case (s)
            2'h0:    boot_col = ERR_COL_RED;
            2'h1:    boot_col = ERR_COL_YELLOW;
            2'h2:    boot_col = ERR_COL_GREEN;
            default: boot_col = ERR_COL_OFF;
        endcase
    endfunction

    always_comb begin
        logic e1;
        logic e2;
        logic ev;
        logic ea;
        logic eb;
        logic ec;
        e1 = !syn[0];
        e2 = !syn[1];
        ev = syn[5];
        ea = e1;
        eb = e2;
        ec = !syn[2];
        st_nxt = st_r;
        // Source mux; power-up jumpers give the redundant defaults
        ea = (syn[6] == `ERR_SEL_A_EVT) ? ev : e1;
        eb = (syn[7] == `ERR_SEL_B_PULSE) ? !syn[3] : e2;
        case (syn[9:8])
            `ERR_SEL_C_10M: ec = !syn[4];
            `ERR_SEL_C_EVT: ec = ev;
            default:        ec = !syn[2];
        endcase
        // Relays alarm from reset on; a dead module must read as error
        st_nxt.ra = ea;
        st_nxt.rb = eb;
        st_nxt.rc = ec;
        case (st_r.phase)
            ERR_PH_INIT: begin
                st_nxt.st = ERR_COL_BLUE;
                st_nxt.a  = ERR_COL_OFF;
                st_nxt.b  = ERR_COL_OFF;
                st_nxt.c  = ERR_COL_OFF;
                if (st_r.cnt >= 32'(INIT_CYC - 1)) begin
                    st_nxt.cnt   = '0;
                    st_nxt.step  = 2'h0;
                    st_nxt.phase = ERR_PH_BOOT;
                end else begin
                    st_nxt.cnt = st_r.cnt + 32'h1;
                end
            end
            ERR_PH_BOOT: begin
                st_nxt.st = ERR_COL_BLUE;
                st_nxt.a  = boot_col(st_r.step);
                st_nxt.b  = boot_col(st_r.step);
                st_nxt.c  = boot_col(st_r.step);
                if (st_r.cnt >= 32'(STEP_CYC - 1)) begin
                    st_nxt.cnt  = '0;
                    st_nxt.step = st_r.step + 2'h1;
                    if (st_r.step == 2'h3) begin
                        st_nxt.phase = ERR_PH_NORMAL;
                    end
                end else begin
                    st_nxt.cnt = st_r.cnt + 32'h1;
                end
            end
            ERR_PH_NORMAL: begin
                st_nxt.st = ERR_COL_GREEN;
                st_nxt.a  = health(e1);
                st_nxt.b  = health(e2);
                st_nxt.c  = health(ev);
            end
            default: begin
                st_nxt.phase = ERR_PH_INIT;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{phase: ERR_PH_INIT, cnt: '0, step: 2'h0,
                      ra: 1'b1, rb: 1'b1, rc: 1'b1,
                      st: ERR_COL_BLUE, a: ERR_COL_OFF,
                      b: ERR_COL_OFF, c: ERR_COL_OFF};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign relay_a_nc  = st_r.ra;
    assign relay_b_nc  = st_r.rb;
    assign relay_c_nc  = st_r.rc;
    assign led_st      = st_r.st;
    assign led_a       = st_r.a;
    assign led_b       = st_r.b;
    assign led_c       = st_r.c;
    assign normal_mode = (st_r.phase == ERR_PH_NORMAL);

    // One clock domain, so every property shares clock and reset
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    relay_a_src_a: assert property (
        syn[6] == `ERR_SEL_A_REF1 |=> relay_a_nc == !$past(syn[0]))
        else $error("relay A does not follow clock one");
    relay_a_evt_a: assert property (
        syn[6] == `ERR_SEL_A_EVT |=> relay_a_nc == $past(syn[5]))
        else $error("relay A does not follow the event");
    relay_b_pulse_a: assert property (
        syn[7] && !syn[3] |=> relay_b_nc)
        else $error("relay B misses pulse error");
    relay_c_sw_a: assert property (
        syn[9:8] == `ERR_SEL_C_SWITCH |=> relay_c_nc == !$past(syn[2]))
        else $error("relay C does not follow the switch");
    relay_c_ten_a: assert property (
        syn[9:8] == `ERR_SEL_C_10M |=> relay_c_nc == !$past(syn[4]))
        else $error("relay C does not follow the 10 MHz signal");
    relay_c_evt_a: assert property (
        syn[9:8] == `ERR_SEL_C_EVT |=> relay_c_nc == $past(syn[5]))
        else $error("relay C does not follow the event");
    relay_ok_a: assert property (
        !syn[6] && syn[0] |=> !relay_a_nc)
        else $error("relay A not open while synchronous");
    relay_err_a: assert property (
        !syn[7] && !syn[1] |=> relay_b_nc)
        else $error("relay B not closed on error");

    boot_step_a: assert property (
        st_r.phase == ERR_PH_BOOT && $changed(st_r.step)
        |-> st_r.step == $past(st_r.step) + 2'h1)
        else $error("boot step skipped");
    init_off_a: assert property (
        st_r.phase == ERR_PH_INIT
        |-> led_a == ERR_COL_OFF && led_b == ERR_COL_OFF
            && led_c == ERR_COL_OFF)
        else $error("LEDs not off during init");

    led_a_norm_a: assert property (
        normal_mode && $past(normal_mode) && !syn[0] |=> led_a == ERR_COL_RED)
        else $error("LED A not red on clock one error");
    led_b_norm_a: assert property (
        normal_mode && syn[1] |=> led_b == ERR_COL_GREEN)
        else $error("LED B not green");
    led_b_err_a: assert property (
        normal_mode && !syn[1] |=> led_b == ERR_COL_RED)
        else $error("LED B not red on clock two error");
    led_c_norm_a: assert property (
        normal_mode && syn[5] |=> led_c == ERR_COL_RED)
        else $error("LED C not red on event");
    led_c_ok_a: assert property (
        normal_mode && !syn[5] |=> led_c == ERR_COL_GREEN)
        else $error("LED C not green without event");
    status_led_a: assert property (
        !normal_mode |-> led_st == ERR_COL_BLUE)
        else $error("status LED not blue before normal");
    status_norm_a: assert property (
        normal_mode |=> led_st == ERR_COL_GREEN)
        else $error("status LED not green in normal operation");
endmodule

// *** tb/err_alarm_panel.sv ***
// Alarm equipment model wired to the three relay contacts
`timescale 1ns/1ps
module err_alarm_panel (
    input  wire logic       relay_a_nc,
    input  wire logic       relay_b_nc,
    input  wire logic       relay_c_nc,
    output logic      [2:0] alarm_lamp
);
    // Lamp lit while common meets the closed contact
    assign alarm_lamp = {relay_c_nc, relay_b_nc, relay_a_nc};
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the error relay status indicator
`timescale 1ns/1ps
module tb;
    import err_pkg::*;
    localparam int STEP = 8;
    localparam int INIT = 4;
    logic       sys_clk;
    logic       arst_n;
    logic       sel_a;
    logic       sel_b;
    logic [1:0] sel_c;
    logic [5:0] pins;
    logic       ra;
    logic       rb;
    logic       rc;
    logic       normal_mode;
    logic [2:0] lamp;
    err_col_t   led_st;
    err_col_t   led_a;
    err_col_t   led_b;
    err_col_t   led_c;
    int         bad_count = 0;
    int         compares = 0;

    // Pins: ref1, ref2, switch, pulse, 10 MHz, notify (msb first)
    err_relay #(.STEP_CYC(STEP), .INIT_CYC(INIT)) u_err_relay (
        .sys_clk(sys_clk), .arst_n(arst_n), .ref1_sync(pins[5]),
        .ref2_sync(pins[4]), .redundancy_switch_controller_ok(pins[3]),
        .pulse_per_second_ok(pins[2]),
        .ten_mhz_ok(pins[1]), .notify_err(pins[0]), .sel_a(sel_a),
        .sel_b(sel_b), .sel_c(sel_c), .relay_a_nc(ra), .relay_b_nc(rb),
        .relay_c_nc(rc), .led_st(led_st), .led_a(led_a), .led_b(led_b),
        .led_c(led_c), .normal_mode(normal_mode));
    err_alarm_panel u_err_alarm_panel (.relay_a_nc(ra), .relay_b_nc(rb),
        .relay_c_nc(rc), .alarm_lamp(lamp));

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [2:0] exp,
                       input logic [2:0] got);
        compares++;
        if (exp !== got) begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic test_init();
        repeat (2) @(negedge sys_clk);
        chk("led_st", ERR_COL_BLUE, led_st);
        chk("led_a", ERR_COL_OFF, led_a);
        chk("led_b", ERR_COL_OFF, led_b);
        chk("led_c", ERR_COL_OFF, led_c);
        chk("normal_mode", 3'h0, {2'h0, normal_mode});
        // Relays still reflect the synchronisers' reset zeros, so every default relay source reads bad
        chk("reset relays", 3'h7, {rc, rb, ra});
        $display("test_init done");
    endtask

    task automatic test_boot();
        err_col_t seq [4] = '{ERR_COL_RED, ERR_COL_YELLOW,
                              ERR_COL_GREEN, ERR_COL_OFF};
        int n;
        n = 0;
        // Bounded wait: the first colour must follow init promptly
        while (led_a !== ERR_COL_RED) begin
            @(negedge sys_clk);
            n++;
            if (n > INIT + 4) begin
                bad_count++;
                $display("ERROR boot start expected 1 seen %0h", led_a);
                test_done();
            end
        end
        repeat (STEP / 2) @(negedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            chk("boot led_a", seq[i], led_a);
            chk("boot led_b", seq[i], led_b);
            chk("boot led_c", seq[i], led_c);
            chk("boot led_st", ERR_COL_BLUE, led_st);
            repeat (STEP) @(negedge sys_clk);
        end
        chk("normal_mode", 3'h1, {2'h0, normal_mode});
        chk("normal led_st", ERR_COL_GREEN, led_st);
        $display("test_boot done");
    endtask

    task automatic test_relays();
        logic [5:0] pat [7] = '{6'h3e, 6'h1e, 6'h2e, 6'h36, 6'h3a,
                               6'h3c, 6'h3f};
        logic [2:0] exp;
        // All jumper settings, one fault at a time on each source
        for (int s = 0; s < 16; s++) begin
            for (int i = 0; i < 7; i++) begin
                {sel_a, sel_b, sel_c} = 4'(s);
                pins = pat[i];
                repeat (4) @(negedge sys_clk);
                exp[0] = sel_a ? pins[0] : !pins[5];
                exp[1] = sel_b ? !pins[2] : !pins[4];
                exp[2] = (sel_c == 2'h1) ? !pins[1] :
                         (sel_c == 2'h2) ? pins[0] : !pins[3];
                chk("relays", exp, {rc, rb, ra});
                chk("alarm lamp", exp, lamp);
                if (s == 0) begin
                    chk("dflt", ~pins[5:3], {ra, rb, rc});
                end
            end
        end
        $display("test_relays done");
    endtask

    task automatic test_leds();
        logic [5:0] pat [4] = '{6'h3e, 6'h1e, 6'h2e, 6'h3f};
        sel_a = 1'b0;
        sel_b = 1'b1;
        sel_c = 2'h1;
        // LED C must ignore the relay C jumper
        for (int i = 0; i < 4; i++) begin
            pins = pat[i];
            repeat (4) @(negedge sys_clk);
            chk("led_a", pins[5] ? ERR_COL_GREEN : ERR_COL_RED,
                led_a);
            chk("led_b", pins[4] ? ERR_COL_GREEN : ERR_COL_RED,
                led_b);
            chk("led_c", pins[0] ? ERR_COL_RED : ERR_COL_GREEN,
                led_c);
        end
        $display("test_leds done");
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial begin
        arst_n = 1'b0;
        pins = 6'h3e;
        sel_a = 1'b0;
        sel_b = 1'b0;
        sel_c = 2'h0;
        repeat (6) @(negedge sys_clk);
        arst_n = 1'b1;
        test_init();
        test_boot();
        test_relays();
        test_leds();
        test_done();
    end
endmodule
